// ===== rtl/qfc_defines.svh
// Register offsets, field positions, reset values and sizes of the flash controller.
// Definitions only; included by bare name wherever a number is needed.
`ifndef QFC_DEFINES_SVH
`define QFC_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define QFC_OFS_XCON1    16'h2000
`define QFC_OFS_XCON2    16'h2004
`define QFC_OFS_CFG      16'h2008
`define QFC_OFS_CON      16'h200C
`define QFC_OFS_CLKCON   16'h2010
`define QFC_OFS_CMDTHR   16'h2014
`define QFC_OFS_INTTHR   16'h2018
`define QFC_OFS_INTEN    16'h201C
`define QFC_OFS_INTSTAT  16'h2020
`define QFC_OFS_TXDATA   16'h2024
`define QFC_OFS_RXDATA   16'h2028
`define QFC_OFS_STAT1    16'h202C
`define QFC_OFS_STAT2    16'h2030
`define QFC_OFS_BDCON    16'h2034
`define QFC_OFS_BDCUR    16'h2038
`define QFC_OFS_BDBASE   16'h2040
`define QFC_RST_WORD     32'h0000_0000

// ****************************************
// Field positions
// ****************************************
`define QFC_CFG_MODE     2:0
`define QFC_CFG_CLOCK_PHASE_SELECT     3
`define QFC_CFG_CLOCK_IDLE_LEVEL     4
`define QFC_CFG_LSB_FIRST     5
`define QFC_CFG_WP       9
`define QFC_CFG_HOLD     10
`define QFC_CFG_SWRST    16
`define QFC_CFG_TXRST    17
`define QFC_CFG_SELF_CLR 32'h000F_0000
`define QFC_CFG_EN       23
`define QFC_CFG_CSEN     25:24
`define QFC_CON_CMD      17:16
`define QFC_CON_LANE     19:18
`define QFC_XCON1_OPC    17:10
`define QFC_CLK_DIV      18:8
`define QFC_CLK_STABLE   32'h0000_0002
`define QFC_BD_DMA_ENABLE     0
`define QFC_BD_POLL      1
`define QFC_BD_START     2
`define QFC_INT_TXEMPTY  0
`define QFC_INT_TXFULL   1
`define QFC_INT_RXEMPTY  3
`define QFC_INT_RXFULL   4
`define QFC_INT_BDDONE   9
`define QFC_INT_PKT      10
`define QFC_INT_DMAE     11

// ****************************************
// Codes and sizes
// ****************************************
`define QFC_MODE_PIO     3'h1
`define QFC_MODE_DMA     3'h2
`define QFC_MODE_XIP     3'h3
`define QFC_LANE_DUAL    2'h1
`define QFC_LANE_QUAD    2'h2
`define QFC_CMD_TX       2'h1
`define QFC_WORD_BITS    6'h20
`define QFC_FIFO_DEPTH   4
`define QFC_FIFO_WIDTH   32

`endif

// ===== rtl/qfc_pkg.sv
// Types shared by the flash controller files.
// Assumes the defines header for widths of nothing here; all types are self-contained.
package qfc_pkg;

  typedef enum logic [0:0] {QFC_IDLE, QFC_SHIFT} qfc_run_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } qfc_bus_t;

  typedef struct packed {
    logic       sck;
    logic [1:0] cs_n;
    logic [3:0] dout;
    logic [3:0] doe;
  } qfc_link_t;

  typedef struct packed {
    logic [31:0] xcon1, xcon2, cfg, con, clkcon, cmdthr, intthr, inten;
    logic [31:0] intstat, bdcon, bdbase, bdcur, rxw, rdata, shreg, rxsh, xipd;
    qfc_run_t    run;
    logic        half, xph, dtx, xipv, rxf, irq;
    logic [5:0]  bitcnt;
    logic [10:0] divcnt;
    qfc_link_t   link;
  } qfc_state_t;

endpackage

// ===== rtl/qfc_sync.sv
// Two-stage synchroniser for levels entering the system clock domain.
// Assumes the reset is asynchronous and active low.
`timescale 1ns/100ps
module qfc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } qfc_sync_t;

  qfc_sync_t st, ns;

  always_comb begin
    ns    = st;
    ns.s1 = d;
    ns.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= ns;
    end
  end

  assign q = st.s2;
endmodule // qfc_sync

// ===== rtl/qfc_fifo.sv
// Word FIFO with valid and ready on both sides and a synchronous flush.
// Assumes one clock; depth is a power of two.
`timescale 1ns/100ps
module qfc_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 flush,
  // Fill side
  input  wire logic                 in_valid,
  input  wire logic [W-1:0]         in_data,
  output logic                      in_ready,
  // Drain side
  output logic                      out_valid,
  output logic      [W-1:0]         out_data,
  input  wire logic                 out_ready,
  output logic      [$clog2(D):0]   level
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } qfc_fifo_t;

  qfc_fifo_t st, ns;
  logic      push, pop;

  assign in_ready  = (st.cnt != (AW+1)'(D));
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rp];
  assign level     = st.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    ns = st;
    if (push) begin
      ns.mem[st.wp] = in_data;
      ns.wp         = st.wp + AW'(1);
    end
    if (pop) begin
      ns.rp = st.rp + AW'(1);
    end
    ns.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      ns.wp  = '0;
      ns.rp  = '0;
      ns.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= ns;
    end
  end
endmodule // qfc_fifo

// ===== rtl/qfc_quad_serial_flash_controller.sv
// Serial flash controller on one, two or four lanes, with register port,
// DMA feed, execute-in-place read port and descriptor address walker.
// Assumes a same-clock register master and DMA/descriptor partners; lanes are pins.
//
// Operation
// - Single/dual lanes: lane 3 shows hold bit.
// - Single/dual lanes: lane 2 shows write-protect bit.
// - lsb_first selects bit order both directions.
// - clock_idle_level sets the resting serial clock level.
// - clock_phase_select: toggle at bit start or middle.
// - Mode codes: 011 in-place, 010 DMA, 001 programmed.
// - In-place mode reads memory with register timing.
// - Leaving in-place mode enters programmed I/O mode.
// - Start bit runs or stops the descriptor processor.
// - DMA movement only while dma_enable set.
// - Current pointer shows descriptor in hand, resets zero.
// - Descriptor control bits 31..3 read zero.
`timescale 1ns/100ps
`include "qfc_defines.svh"
module qfc_quad_serial_flash_controller (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // Register port
  input  wire qfc_pkg::qfc_bus_t bus,
  output logic      [31:0]       rdata,
  // Flash link
  input  wire logic [3:0]        lane_in,
  output qfc_pkg::qfc_link_t     link,
  // DMA feed
  input  wire logic              dma_valid,
  input  wire logic [31:0]       dma_data,
  output logic                   dma_ready,
  // Execute-in-place port
  input  wire logic              xip_req,
  input  wire logic [23:0]       xip_addr,
  output logic                   xip_ack,
  output logic                   xip_valid,
  output logic      [31:0]       xip_data,
  // Descriptor fetch
  output logic                   desc_req,
  output logic      [31:0]       desc_addr,
  input  wire logic              desc_ack,
  input  wire logic [31:0]       desc_next,
  // Request line
  output logic                   int_req
);
  qfc_pkg::qfc_state_t st, ns;
  logic        rst_n, tick, lsb_first, active, txon, push_bus, flush, is_dma;
  logic [2:0]  mode, f_level;
  logic [1:0]  lc;
  logic [3:0]  lane_s, head, rin;
  logic [5:0]  nl;
  logic [31:0] sh_o, rx_o, f_out_data, f_in_data;
  logic [15:0] hw_set, w1c;
  logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready;

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  qfc_sync #(.W(1)) u_rst_sync (
    .clk   (clk_sys),
    .rst_n (nrst),
    .d     (1'b1),
    .q     (rst_n)
  );

  qfc_sync #(.W(4)) u_lane_sync (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .d     (lane_in),
    .q     (lane_s)
  );

  // ****************************************
  // Transmit FIFO
  // ****************************************
  // Back-pressure reaches the DMA source through dma_ready; a register write
  // into a full FIFO is dropped and shows as the full flag.
  assign mode       = st.cfg[`QFC_CFG_MODE];
  assign is_dma     = (mode == `QFC_MODE_DMA);
  assign f_in_valid = is_dma ? (dma_valid & st.bdcon[`QFC_BD_DMA_ENABLE]) : push_bus;
  assign f_in_data  = is_dma ? dma_data : bus.wdata;
  assign dma_ready  = is_dma & st.bdcon[`QFC_BD_DMA_ENABLE] & f_in_ready;

  qfc_fifo #(.W(`QFC_FIFO_WIDTH), .D(`QFC_FIFO_DEPTH)) u_tx_fifo (
    .clk       (clk_sys),
    .rst_n     (rst_n),
    .flush     (flush),
    .in_valid  (f_in_valid),
    .in_data   (f_in_data),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (f_out_ready),
    .level     (f_level)
  );

  // ****************************************
  // Lane selection and bit order
  // ****************************************
  assign lc   = st.con[`QFC_CON_LANE];
  assign lsb_first = st.cfg[`QFC_CFG_LSB_FIRST];
  assign tick = (st.divcnt == st.clkcon[`QFC_CLK_DIV]);
  assign txon = st.dtx & (st.run == qfc_pkg::QFC_SHIFT);

  always_comb begin
    case (lc)
      `QFC_LANE_QUAD: begin
        nl   = 6'h04;
        rin  = lane_s;
        head = lsb_first ? st.shreg[3:0] : st.shreg[31:28];
        sh_o = lsb_first ? {4'h0, st.shreg[31:4]} : {st.shreg[27:0], 4'h0};
        rx_o = lsb_first ? {rin, st.rxsh[31:4]} : {st.rxsh[27:0], rin};
      end
      `QFC_LANE_DUAL: begin
        nl   = 6'h02;
        rin  = {2'h0, lane_s[1:0]};
        head = {2'h0, (lsb_first ? st.shreg[1:0] : st.shreg[31:30])};
        sh_o = lsb_first ? {2'h0, st.shreg[31:2]} : {st.shreg[29:0], 2'h0};
        rx_o = lsb_first ? {rin[1:0], st.rxsh[31:2]} : {st.rxsh[29:0], rin[1:0]};
      end
      default: begin
        nl   = 6'h01;
        rin  = {3'h0, lane_s[1]};
        head = {3'h0, (lsb_first ? st.shreg[0] : st.shreg[31])};
        sh_o = lsb_first ? {1'h0, st.shreg[31:1]} : {st.shreg[30:0], 1'h0};
        rx_o = lsb_first ? {rin[0], st.rxsh[31:1]} : {st.rxsh[30:0], rin[0]};
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    ns          = st;
    ns.rdata    = `QFC_RST_WORD;
    ns.xipv     = 1'b0;
    hw_set      = 16'h0000;
    w1c         = 16'h0000;
    push_bus    = 1'b0;
    flush       = 1'b0;
    f_out_ready = 1'b0;
    xip_ack     = 1'b0;
    // Serial engine. Each bit spans two ticks of the divider; the middle
    // of the bit samples, the end of the bit shifts.
    if (st.run == qfc_pkg::QFC_SHIFT) begin
      ns.divcnt = tick ? 11'h000 : st.divcnt + 11'h001;
      if (tick && !st.half) begin
        ns.half = 1'b1;
        ns.rxsh = rx_o;
      end else if (tick) begin
        ns.half   = 1'b0;
        ns.shreg  = sh_o;
        ns.bitcnt = st.bitcnt + nl;
        if (ns.bitcnt == `QFC_WORD_BITS) begin
          ns.rxw                   = st.rxsh;
          ns.rxf                   = 1'b1;
          hw_set[`QFC_INT_RXFULL]  = 1'b1;
          hw_set[`QFC_INT_PKT]     = 1'b1;
          ns.bitcnt                = 6'h00;
          if (mode == `QFC_MODE_XIP && !st.xph) begin
            ns.xph   = 1'b1;
            ns.dtx   = 1'b0;
            ns.shreg = `QFC_RST_WORD;
          end else begin
            ns.run  = qfc_pkg::QFC_IDLE;
            ns.xipv = (mode == `QFC_MODE_XIP);
            ns.xipd = st.rxsh;
          end
        end
      end
    end else begin
      ns.divcnt = 11'h000;
      ns.half   = 1'b0;
      ns.bitcnt = 6'h00;
      if (st.cfg[`QFC_CFG_EN]) begin
        if (mode == `QFC_MODE_XIP) begin
          if (xip_req) begin
            xip_ack  = 1'b1;
            ns.shreg = {st.xcon1[`QFC_XCON1_OPC], xip_addr};
            ns.dtx   = 1'b1;
            ns.xph   = 1'b0;
            ns.run   = qfc_pkg::QFC_SHIFT;
          end
        end else if ((mode == `QFC_MODE_PIO || is_dma) && st.con[`QFC_CON_CMD] != 2'h0
                     && f_out_valid) begin
          f_out_ready = 1'b1;
          ns.shreg    = f_out_data;
          ns.dtx      = (st.con[`QFC_CON_CMD] == `QFC_CMD_TX);
          ns.run      = qfc_pkg::QFC_SHIFT;
        end
      end
    end
    // Descriptor walker: each accepted fetch moves the pointer on.
    if (desc_req && desc_ack) begin
      ns.bdcur                 = desc_next;
      hw_set[`QFC_INT_BDDONE]  = 1'b1;
    end
    // Register writes.
    if (bus.wr) begin
      if (bus.addr == `QFC_OFS_XCON1) begin
        ns.xcon1 = bus.wdata;
      end else if (bus.addr == `QFC_OFS_XCON2) begin
        ns.xcon2 = bus.wdata;
      end else if (bus.addr == `QFC_OFS_CFG) begin
        ns.cfg = bus.wdata & ~`QFC_CFG_SELF_CLR;
        if (mode == `QFC_MODE_XIP && bus.wdata[`QFC_CFG_MODE] != `QFC_MODE_XIP) begin
          ns.cfg[`QFC_CFG_MODE] = `QFC_MODE_PIO;
        end
        if (bus.wdata[`QFC_CFG_SWRST]) begin
          ns.run = qfc_pkg::QFC_IDLE;
          flush  = 1'b1;
        end
        if (bus.wdata[`QFC_CFG_TXRST]) begin
          flush = 1'b1;
        end
      end else if (bus.addr == `QFC_OFS_CON) begin
        ns.con = bus.wdata;
      end else if (bus.addr == `QFC_OFS_CLKCON) begin
        ns.clkcon = bus.wdata & ~`QFC_CLK_STABLE;
      end else if (bus.addr == `QFC_OFS_CMDTHR) begin
        ns.cmdthr = bus.wdata;
      end else if (bus.addr == `QFC_OFS_INTTHR) begin
        ns.intthr = bus.wdata;
      end else if (bus.addr == `QFC_OFS_INTEN) begin
        ns.inten = bus.wdata;
      end else if (bus.addr == `QFC_OFS_INTSTAT) begin
        w1c = bus.wdata[15:0];
      end else if (bus.addr == `QFC_OFS_TXDATA) begin
        push_bus = (mode == `QFC_MODE_PIO);
      end else if (bus.addr == `QFC_OFS_BDCON) begin
        ns.bdcon = {29'h0000_0000, bus.wdata[2:0]};
        if (bus.wdata[`QFC_BD_START] && !st.bdcon[`QFC_BD_START]) begin
          ns.bdcur = st.bdbase;
        end
      end else if (bus.addr == `QFC_OFS_BDBASE) begin
        ns.bdbase = bus.wdata;
      end
    end
    // Register reads; data stands in the following cycle only.
    if (bus.rd) begin
      if (bus.addr == `QFC_OFS_XCON1) begin
        ns.rdata = st.xcon1;
      end else if (bus.addr == `QFC_OFS_XCON2) begin
        ns.rdata = st.xcon2;
      end else if (bus.addr == `QFC_OFS_CFG) begin
        ns.rdata = st.cfg;
      end else if (bus.addr == `QFC_OFS_CON) begin
        ns.rdata = st.con;
      end else if (bus.addr == `QFC_OFS_CLKCON) begin
        ns.rdata = st.clkcon | (st.clkcon[0] ? `QFC_CLK_STABLE : `QFC_RST_WORD);
      end else if (bus.addr == `QFC_OFS_CMDTHR) begin
        ns.rdata = st.cmdthr;
      end else if (bus.addr == `QFC_OFS_INTTHR) begin
        ns.rdata = st.intthr;
      end else if (bus.addr == `QFC_OFS_INTEN) begin
        ns.rdata = st.inten;
      end else if (bus.addr == `QFC_OFS_INTSTAT) begin
        ns.rdata = st.intstat;
      end else if (bus.addr == `QFC_OFS_RXDATA) begin
        ns.rdata                 = st.rxw;
        ns.rxf                   = 1'b0;
        hw_set[`QFC_INT_RXEMPTY] = 1'b1;
      end else if (bus.addr == `QFC_OFS_STAT1) begin
        ns.rdata = {8'h00, 8'(`QFC_FIFO_DEPTH) - {5'h00, f_level}, 15'h0000, st.rxf};
      end else if (bus.addr == `QFC_OFS_STAT2) begin
        ns.rdata = {24'h00_0000, lane_s, 4'h0};
      end else if (bus.addr == `QFC_OFS_BDCON) begin
        ns.rdata = st.bdcon;
      end else if (bus.addr == `QFC_OFS_BDCUR) begin
        ns.rdata = st.bdcur;
      end else if (bus.addr == `QFC_OFS_BDBASE) begin
        ns.rdata = st.bdbase;
      end
    end
    // Sticky flags: a hardware set in the same cycle as a clear wins.
    hw_set[`QFC_INT_TXEMPTY] = ~f_out_valid;
    hw_set[`QFC_INT_TXFULL]  = ~f_in_ready;
    hw_set[`QFC_INT_DMAE]    = is_dma & dma_valid & ~st.bdcon[`QFC_BD_DMA_ENABLE];
    ns.intstat = (st.intstat & ~{16'h0000, w1c}) | {16'h0000, hw_set};
    ns.irq     = |(ns.intstat & ns.inten);
    // Pins, registered. The clock pulse falls in the half of the bit that
    // the phase bit selects; idle level comes from the polarity bit.
    active       = st.cfg[`QFC_CFG_CLOCK_PHASE_SELECT] ? ~st.half : st.half;
    ns.link.sck  = st.cfg[`QFC_CFG_CLOCK_IDLE_LEVEL] ^ ((st.run == qfc_pkg::QFC_SHIFT) & active);
    ns.link.cs_n = (st.run == qfc_pkg::QFC_SHIFT) ? ~st.cfg[`QFC_CFG_CSEN] : 2'h3;
    case (lc)
      `QFC_LANE_QUAD: begin
        ns.link.dout = head;
        ns.link.doe  = {4{txon}};
      end
      `QFC_LANE_DUAL: begin
        ns.link.dout = {st.cfg[`QFC_CFG_HOLD], st.cfg[`QFC_CFG_WP], head[1:0]};
        ns.link.doe  = {2'h3, {2{txon}}};
      end
      default: begin
        ns.link.dout = {st.cfg[`QFC_CFG_HOLD], st.cfg[`QFC_CFG_WP], 1'b0, head[0]};
        ns.link.doe  = 4'hD;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st           <= '0;
      st.link.cs_n <= 2'h3;
    end else begin
      st <= ns;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata     = st.rdata;
  assign link      = st.link;
  assign xip_valid = st.xipv;
  assign xip_data  = st.xipd;
  assign desc_req  = st.bdcon[`QFC_BD_START] & st.bdcon[`QFC_BD_POLL];
  assign desc_addr = st.bdcur;
  assign int_req   = st.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_hold_lane3: assert property (
    (rst_n && lc != `QFC_LANE_QUAD)
    |=> (link.dout[3] == $past(st.cfg[`QFC_CFG_HOLD]) && link.doe[3]))
    else $error("Lane 3 does not follow the hold bit.");
  a_wp_lane2: assert property (
    (rst_n && lc != `QFC_LANE_QUAD)
    |=> (link.dout[2] == $past(st.cfg[`QFC_CFG_WP]) && link.doe[2]))
    else $error("Lane 2 does not follow the write-protect bit.");
  a_bit_order: assert property (
    (st.run == qfc_pkg::QFC_SHIFT && lc == 2'h0 && !lsb_first)
    |=> link.dout[0] == $past(st.shreg[31]))
    else $error("Single lane does not send the top bit first.");
  a_idle_clock: assert property (
    (st.run == qfc_pkg::QFC_IDLE) |=> link.sck == $past(st.cfg[`QFC_CFG_CLOCK_IDLE_LEVEL]))
    else $error("Idle serial clock level is wrong.");
  a_phase_start: assert property (
    (st.run == qfc_pkg::QFC_SHIFT && !st.half && st.cfg[`QFC_CFG_CLOCK_PHASE_SELECT])
    |=> link.sck != $past(st.cfg[`QFC_CFG_CLOCK_IDLE_LEVEL]))
    else $error("Clock does not toggle at bit start.");
  a_xip_mode: assert property (
    xip_ack |=> (st.run == qfc_pkg::QFC_SHIFT && !st.xph && st.dtx))
    else $error("In-place read did not start its command word.");
  a_leave_xip: assert property (
    (bus.wr && bus.addr == `QFC_OFS_CFG && mode == `QFC_MODE_XIP
     && bus.wdata[2:0] != `QFC_MODE_XIP) |=> mode == `QFC_MODE_PIO)
    else $error("Leaving in-place mode did not select programmed mode.");
  a_start_gate: assert property (
    !st.bdcon[`QFC_BD_START] |-> !desc_req)
    else $error("Descriptor fetch while stopped.");
  a_poll_gate: assert property (
    (st.bdcon[`QFC_BD_START] && !st.bdcon[`QFC_BD_POLL]) |-> !desc_req)
    else $error("Descriptor fetch while polling is off.");
  a_dma_gate: assert property (
    dma_ready |-> (st.bdcon[`QFC_BD_DMA_ENABLE] && is_dma))
    else $error("DMA accepted while disabled.");
  a_cur_pointer: assert property (
    (desc_req && desc_ack) |=> desc_addr == $past(desc_next))
    else $error("Current pointer did not follow the fetch.");
  a_bdcon_rsvd: assert property (
    (bus.rd && bus.addr == `QFC_OFS_BDCON) |=> rdata[31:3] == 29'h0000_0000)
    else $error("Descriptor control upper bits read nonzero.");
  a_flag_request: assert property (
    (bus.wr && bus.addr == `QFC_OFS_INTEN && (bus.wdata[15:0] & st.intstat[15:0]) != 16'h0000)
    ##1 1'b1 |=> int_req)
    else $error("Enabled flag raised no request.");
  a_base_fetch: assert property (
    (bus.wr && bus.addr == `QFC_OFS_BDCON && bus.wdata[2] && !st.bdcon[2] && !desc_ack)
    |=> desc_addr == $past(st.bdbase))
    else $error("Start did not load the base pointer.");
endmodule // qfc_quad_serial_flash_controller

// ===== sim/qfc_flash_model.sv
// Stand-in for the serial flash on the lane pins.
// Assumes the controller's link struct and the system clock.
`timescale 1ns/100ps
module qfc_flash_model (
  // Clock
  input  wire logic               clk,
  // Link
  input  wire qfc_pkg::qfc_link_t link,
  output logic [3:0]              lane_in
);
  logic [3:0] idle_pat = 4'h5;
  // Unselected lanes toggle each cycle, so a stale bit never passes for data.
  always @(posedge clk) begin
    idle_pat <= ~idle_pat;
  end
  // The memory answers all ones on released lanes while selected.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_in[i] = link.doe[i] ? link.dout[i] : (link.cs_n[0] ? idle_pat[i] : 1'b1);
    end
  end
endmodule // qfc_flash_model

// ===== sim/qfc_quad_serial_flash_controller_tb_top.sv
// Register-level bench of the flash controller.
// Assumes the flash model on the lanes and a 200 MHz system clock.
`timescale 1ns/100ps
`include "qfc_defines.svh"
module qfc_quad_serial_flash_controller_tb_top;
  logic               clk_sys   = 1'b0;
  logic               nrst      = 1'b0;
  qfc_pkg::qfc_bus_t  bus       = '0;
  logic               desc_ack  = 1'b0;
  logic [31:0]        desc_next = 32'h0000_ABC0;
  logic [31:0]        rdata, dv, desc_addr, xip_data;
  logic [3:0]         lane_in;
  qfc_pkg::qfc_link_t link;
  logic               xip_req   = 1'b0;
  logic               dma_ready, desc_req, xip_ack, xip_valid, int_req;
  int                 n_fail    = 0;
  int                 n_tests   = 0;
  logic [15:0]        ofs [5]   = '{`QFC_OFS_CFG, `QFC_OFS_CON, `QFC_OFS_BDCON,
                                    `QFC_OFS_BDCUR, 16'h203C};
  logic [31:0]        pin_cfg [2] = '{32'h0000_1401, 32'h0000_1211};
  logic [4:0]         pin_exp [2] = '{5'h0B, 5'h17};

  always #2.5 clk_sys = ~clk_sys;

  qfc_quad_serial_flash_controller qfc_quad_serial_flash_controller_inst (
    .clk_sys(clk_sys), .nrst(nrst), .bus(bus), .rdata(rdata), .lane_in(lane_in),
    .link(link), .dma_valid(1'b0), .dma_data(32'h0), .dma_ready(dma_ready),
    .xip_req(xip_req), .xip_addr(24'h00_0100), .xip_ack(xip_ack), .xip_valid(xip_valid),
    .xip_data(xip_data), .desc_req(desc_req), .desc_addr(desc_addr), .desc_ack(desc_ack),
    .desc_next(desc_next), .int_req(int_req));
  qfc_flash_model qfc_flash_model_inst (.clk(clk_sys), .link(link), .lane_in(lane_in));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] d);
    @(posedge clk_sys);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rc(string name, logic [15:0] a, logic [31:0] e);
    @(posedge clk_sys);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 dv = rdata;
    if (name != "") chk(name, e, dv);
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    foreach (ofs[i]) rc("reset", ofs[i], 32'h0);
    // The empty transmit FIFO keeps flag 0 set, so only its enable decides the request.
    wr(`QFC_OFS_INTEN, 32'h0000_0001);
    chk("int_req", 32'h1, {31'h0, int_req});
    wr(`QFC_OFS_INTEN, 32'h0000_0000);
    chk("int_req", 32'h0, {31'h0, int_req});
    wr(`QFC_OFS_BDCON, 32'hFFFF_FFFF);
    rc("bdcon", `QFC_OFS_BDCON, 32'h7);
    wr(`QFC_OFS_BDCON, 32'h0);
    wr(`QFC_OFS_CFG, 32'h0000_1002);
    rc("mode", `QFC_OFS_CFG, 32'h0000_1002);
    wr(`QFC_OFS_CFG, 32'h0000_1003);
    rc("mode", `QFC_OFS_CFG, 32'h0000_1003);
    wr(`QFC_OFS_CFG, 32'h0000_1002);
    rc("mode", `QFC_OFS_CFG, 32'h0000_1001);
    foreach (pin_cfg[i]) begin
      wr(`QFC_OFS_CFG, pin_cfg[i]);
      repeat (3) @(posedge clk_sys);
      #1;
      chk("pins", pin_exp[i], {link.sck, link.dout[3:2], link.doe[3:2]});
    end
    wr(`QFC_OFS_BDBASE, 32'h1234_5670);
    wr(`QFC_OFS_BDCON, 32'h6);
    @(posedge clk_sys);
    #1;
    chk("desc_addr", 32'h1234_5670, desc_addr);
    chk("desc_req", 32'h1, desc_req);
    desc_ack <= 1'b1;
    @(posedge clk_sys);
    desc_ack <= 1'b0;
    rc("current", `QFC_OFS_BDCUR, 32'h0000_ABC0);
    wr(`QFC_OFS_BDCON, 32'h4);
    chk("desc_req", 32'h0, desc_req);
    wr(`QFC_OFS_BDCON, 32'h2);
    chk("desc_req", 32'h0, desc_req);
    wr(`QFC_OFS_CFG, 32'h0000_1002);
    wr(`QFC_OFS_BDCON, 32'h1);
    chk("dma_ready", 32'h1, dma_ready);
    wr(`QFC_OFS_BDCON, 32'h0);
    chk("dma_ready", 32'h0, dma_ready);
    // Single-lane receive, lsb first. A divider of 3 puts each lane sample past the pin
    // register and both synchroniser stages; a faster serial clock would read stale lanes.
    wr(`QFC_OFS_CFG, 32'h0180_1021);
    wr(`QFC_OFS_CON, 32'h0002_0000);
    wr(`QFC_OFS_CLKCON, 32'h0000_0301);
    wr(`QFC_OFS_TXDATA, 32'h0000_0001);
    repeat (4) @(posedge clk_sys);
    #1 chk("lsb on lane 0", 32'h1, {31'h0, link.dout[0]});
    dv = 32'h0;
    for (int k = 0; k < 400 && dv[0] !== 1'b1; k++) rc("", `QFC_OFS_STAT1, 32'h0);
    chk("word present", 32'h1, {31'h0, dv[0]});
    rc("rx word", `QFC_OFS_RXDATA, 32'hFFFF_FFFF);
    // In-place read, msb first; the released lane 1 answers ones in both phases.
    wr(`QFC_OFS_CFG, 32'h0180_1003);
    xip_req <= 1'b1;
    #1 chk("xip_ack", 32'h1, {31'h0, xip_ack});
    @(posedge clk_sys);
    xip_req <= 1'b0;
    for (int k = 0; k < 700 && xip_valid !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("xip_valid", 32'h1, {31'h0, xip_valid});
    chk("xip_data", 32'hFFFF_FFFF, xip_data);
    wr(`QFC_OFS_CFG, 32'h0000_1001);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    report_and_stop();
  end
endmodule // qfc_quad_serial_flash_controller_tb_top
